// >>> hdl/lsc_pkg.sv
// package for the led sink common configuration register bank
package lsc_pkg;
  // register offsets
  localparam logic [7:0] LSC_COMMON_CFG_OFS = 8'h78;
  localparam logic [7:0] LSC_DROPOUT_REF_OFS = 8'h79;
  // field positions in led_common_cfg
  localparam int LSC_TRACK_BIT = 7;
  localparam int LSC_OPEN_LSB = 2;
  localparam int LSC_STEP_LSB = 0;
  // reset values
  localparam logic LSC_TRACK_RST = 1'h0;
  localparam logic [1:0] LSC_STEP_RST = 2'h0;
  localparam logic [1:0] LSC_TARGET_RST = 2'h0;
  // dropout target codes, millivolts
  localparam logic [1:0] LSC_TARGET_200MV = 2'h0;
  localparam logic [1:0] LSC_TARGET_300MV = 2'h1;
  localparam logic [1:0] LSC_TARGET_400MV = 2'h2;
  localparam logic [1:0] LSC_TARGET_500MV = 2'h3;
  // step code 00 is the 0.6 mA increment
  localparam logic [1:0] LSC_STEP_600UA = 2'h0;
  // sink channel count
  localparam int LSC_CHANNELS = 3;
endpackage

// >>> hdl/lsc_regs.sv
// register bank shared by the three led current sinks
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module lsc_regs
  import lsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // analog front end status per sink channel
  input wire logic [2:0] sink_at_or_below_thr,
  input wire logic [2:0] sink_enabled,
  // controls to boost and sinks
  output logic boost_tracking_enable,
  output logic track_active,
  output logic [1:0] track_target,
  output logic [1:0] current_step_select
);

  logic [1:0] dropout_target_select;
  logic [2:0] open_detect_flags;

  // address decode
  wire sel_common = (addr == LSC_COMMON_CFG_OFS);
  wire sel_ref = (addr == LSC_DROPOUT_REF_OFS);
  wire wr_common = wr && sel_common;
  wire wr_ref = wr && sel_ref;

  // open flags per channel; "only disabled" judged against others still enabled
  wire all_off = (sink_enabled == 3'h0);
  wire [2:0] next_open;
  genvar g;
  generate
    for (g = 0; g < LSC_CHANNELS; g = g + 1)
    begin : g_open
      // channel g lands in bit g of the field, so channel 0 is lowest
      assign next_open[g] = !all_off && (!sink_enabled[g] || sink_at_or_below_thr[g]);
    end
  endgenerate

  // read mux; unused bits stay zero
  wire [7:0] rd_common = {boost_tracking_enable, 2'h0, open_detect_flags, current_step_select};
  wire [7:0] rd_ref = {6'h00, dropout_target_select};
  wire [7:0] next_rdata = !rd ? 8'h00 : sel_common ? rd_common : sel_ref ? rd_ref : 8'h00;

  // writable fields; flags are not written by software
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      boost_tracking_enable <= LSC_TRACK_RST;
      current_step_select <= LSC_STEP_RST;
      dropout_target_select <= LSC_TARGET_RST;
    end
    else
    begin
      if (wr_common)
      begin
        boost_tracking_enable <= wdata[LSC_TRACK_BIT];
        current_step_select <= wdata[LSC_STEP_LSB +: 2];
      end
      if (wr_ref)
        dropout_target_select <= wdata[1:0];
    end
  end

  // status sampling, read data and boost loop outputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      open_detect_flags <= 3'h0;
      rdata <= 8'h00;
      track_active <= 1'h0;
      track_target <= LSC_TARGET_RST;
    end
    else
    begin
      open_detect_flags <= next_open;
      rdata <= next_rdata;
      // the target only reaches the boost loop while tracking is on
      track_active <= boost_tracking_enable;
      track_target <= boost_tracking_enable ? dropout_target_select : LSC_TARGET_RST;
    end
  end

  // checks
  // all assertions sample on the rising clock and sleep while reset is low;
  // read data checks look one cycle after the strobe, where the data stand

  // dropout ref read returns the stored target with zero upper bits
  read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd && sel_ref |=> rdata == {6'h00, dropout_target_select})
    else $error("dropout ref read data wrong");

  // a software write never reaches the flags
  flags_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_common |=> $stable(open_detect_flags) || open_detect_flags == $past(next_open))
    else $error("open flags changed by write");

  // all channels off clears every flag
  all_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    all_off |=> open_detect_flags == 3'h0)
    else $error("flags set with all channels off");

  // channel 0 alone disabled is flagged in the lowest bit
  only_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !all_off && !sink_enabled[0] |=> open_detect_flags[0])
    else $error("disabled channel 0 not flagged");

  // channel 2 above threshold reads clear in the highest bit
  above_thr_a: assert property (@(posedge clk) disable iff (!rst_n)
    sink_enabled[2] && !sink_at_or_below_thr[2] |=> !open_detect_flags[2])
    else $error("channel 2 flagged above threshold");

  // nothing of the target reaches the boost loop while tracking is off
  track_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !boost_tracking_enable |=> !track_active && track_target == 2'h0)
    else $error("tracking leaks while disabled");

  // a new target reaches the loop two cycles after its write and is checked on the third
  track_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ref && boost_tracking_enable && !wr_common
    |-> ##3 track_target == $past(wdata[1:0], 3))
    else $error("target not applied");

  // step select keeps what was written
  step_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_common |=> current_step_select == $past(wdata[1:0]))
    else $error("step select not stored");

  // common register read shows every field in its place
  read_common_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd && sel_common |=> rdata == {$past(boost_tracking_enable), 2'h0,
      $past(open_detect_flags), $past(current_step_select)})
    else $error("common read data wrong");

  // read data fall back to zero outside the answer cycle
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00)
    else $error("read data not idle");

  // unmapped addresses read as zero
  unmapped_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd && !sel_common && !sel_ref |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // the target field keeps what was written
  ref_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ref |=> dropout_target_select == $past(wdata[1:0]))
    else $error("target not stored");

  // tracking enable keeps bit 7 of the write
  track_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_common |=> boost_tracking_enable == $past(wdata[LSC_TRACK_BIT]))
    else $error("tracking enable not stored");

  // without a write to it the common register holds
  hold_cfg_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_common |=> $stable(boost_tracking_enable) && $stable(current_step_select))
    else $error("common register changed unasked");

  // without a write to it the target holds
  hold_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_ref |=> $stable(dropout_target_select))
    else $error("target changed unasked");

  // tracking on reaches the boost loop one cycle later
  track_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    boost_tracking_enable |=> track_active)
    else $error("tracking not passed on");

  // while tracking the loop sees the stored target
  track_target_a: assert property (@(posedge clk) disable iff (!rst_n)
    boost_tracking_enable |=> track_target == $past(dropout_target_select))
    else $error("loop target differs");

  // channel 1 at or below threshold is flagged in the middle bit
  open_thr_a: assert property (@(posedge clk) disable iff (!rst_n)
    sink_enabled[1] && sink_at_or_below_thr[1] |=> open_detect_flags[1])
    else $error("channel 1 open not flagged");

  // channel 2 alone disabled is flagged in the highest bit
  only_off_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    !all_off && !sink_enabled[2] |=> open_detect_flags[2])
    else $error("disabled channel 2 not flagged");

  // channel 0 above threshold reads clear
  above_thr_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    sink_enabled[0] && !sink_at_or_below_thr[0] |=> !open_detect_flags[0])
    else $error("channel 0 flagged above threshold");

  // scenarios worth seeing at least once

  // tracking switched on by software
  cov_track: cover property (@(posedge clk)
    wr_common && wdata[7]);

  // every channel flagged at once
  cov_open: cover property (@(posedge clk)
    open_detect_flags == 3'h7);

  // common register read back
  cov_rd: cover property (@(posedge clk)
    rd && sel_common);

  // one channel disabled while others run
  cov_only_off: cover property (@(posedge clk)
    !all_off && !sink_enabled[1]);

  // target register read back
  cov_ref_rd: cover property (@(posedge clk)
    rd && sel_ref);

endmodule // lsc_regs
`default_nettype wire

// >>> verification/lsc_regs_test.sv
// self-checking bench for the led sink register bank
`timescale 1ns/1ns
`default_nettype none
module lsc_regs_test
  import lsc_pkg::*;
;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [2:0] open_set = 3'h0, en_set = 3'h7;
  wire [7:0] rdata;
  wire [2:0] thr, en;
  wire [1:0] tgt, stp;
  wire bte, ta;
  int mismatches = 0, n_tests = 0;
  lsc_strings strings (.clk(clk), .open_set(open_set), .en_set(en_set),
    .sink_at_or_below_thr(thr), .sink_enabled(en));
  lsc_regs uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sink_at_or_below_thr(thr), .sink_enabled(en),
    .boost_tracking_enable(bte), .track_active(ta), .track_target(tgt),
    .current_step_select(stp));
  // free-running clock
  initial forever #5 clk = ~clk;
  task tally_and_finish;
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // flags lag two cycles: model register plus design sample
  task flag_case(input logic [2:0] o, input logic [2:0] e, input logic [2:0] f);
    @(posedge clk);
    open_set <= o;
    en_set <= e;
    repeat (4) @(posedge clk);
    rd_reg(LSC_COMMON_CFG_OFS, {3'h0, f, 2'h0});
  endtask
  task t_fields;
    wr_reg(LSC_COMMON_CFG_OFS, 8'hff);
    repeat (3) @(negedge clk);
    chk({bte, 5'h0, stp}, 8'h83);
    rd_reg(LSC_COMMON_CFG_OFS, 8'h83);
    wr_reg(LSC_DROPOUT_REF_OFS, 8'hff);
    rd_reg(LSC_DROPOUT_REF_OFS, 8'h03);
    chk({ta, 5'h0, tgt}, 8'h83);
    wr_reg(LSC_COMMON_CFG_OFS, 8'h00);
    repeat (3) @(negedge clk);
    chk({ta, bte, 4'h0, tgt}, 8'h00);
  endtask
  // bounded run guard
  initial
  begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(LSC_COMMON_CFG_OFS, 8'h00);
    rd_reg(LSC_DROPOUT_REF_OFS, 8'h00);
    rd_reg(8'h00, 8'h00);
    t_fields;
    flag_case(3'h1, 3'h7, 3'h1);
    flag_case(3'h4, 3'h7, 3'h4);
    flag_case(3'h0, 3'h5, 3'h2);
    flag_case(3'h7, 3'h0, 3'h0);
    tally_and_finish;
  end
endmodule // lsc_regs_test
`default_nettype wire

// >>> verification/lsc_strings.sv
// led string model feeding the sink status lines
`timescale 1ns/1ns
`default_nettype none
module lsc_strings (
  // clock
  input wire logic clk,
  // string state set by the bench
  input wire logic [2:0] open_set,
  input wire logic [2:0] en_set,
  // sink status toward the block
  output logic [2:0] sink_at_or_below_thr,
  output logic [2:0] sink_enabled
);
  // registered, like the sink comparators
  always_ff @(posedge clk)
  begin
    sink_at_or_below_thr <= open_set;
    sink_enabled <= en_set;
  end
endmodule // lsc_strings
`default_nettype wire
